// >>> hdl/ldic_cfg.svh
`ifndef LDIC_CFG_SVH
`define LDIC_CFG_SVH
// ==========================================================
// Register indexes (byte address = 4 * index)
`define LDIC_IDX_PATTERN 6'h0D
`define LDIC_IDX_LOOP 6'h0E
`define LDIC_IDX_CODE_LEN 6'h0F
`define LDIC_IDX_TX_CODE 6'h10
`define LDIC_IDX_ACT_CODE 6'h11
`define LDIC_IDX_DEACT_CODE 6'h12
`define LDIC_IDX_INJ_CNT 6'h13
`define LDIC_IDX_MASK_LINE 6'h14
`define LDIC_IDX_MASK_ERR 6'h15
`define LDIC_IDX_EDGE 6'h16
`define LDIC_IDX_STATUS_A 6'h17
`define LDIC_IDX_IRQ_LINE 6'h19
`define LDIC_IDX_IRQ_ERR 6'h1A
`define LDIC_IDX_CNT_LO 6'h1B
`define LDIC_IDX_CNT_HI 6'h1C
// ==========================================================
// Reset values and writable-bit masks
`define LDIC_RST_PATTERN 8'h00
`define LDIC_RST_LOOP 8'h00
`define LDIC_RST_CODE_LEN 8'h01
`define LDIC_RST_TX_CODE 8'h01
`define LDIC_RST_ACT_CODE 8'h01
`define LDIC_RST_DEACT_CODE 8'h09
`define LDIC_RST_INJ_CNT 8'h00
`define LDIC_RST_MASK 8'hFF
`define LDIC_RST_EDGE 8'h00
`define LDIC_WM_PATTERN 8'h7F
`define LDIC_WM_LOOP 8'h0F
`define LDIC_WM_CODE_LEN 8'h3F
`define LDIC_WM_INJ_CNT 8'h7F
// ==========================================================
// Field positions
`define LDIC_B_SEQ_HI 6
`define LDIC_B_SEQ_LO 5
`define LDIC_B_SEQ_CLK 4
`define LDIC_B_PR_INVERT 3
`define LDIC_B_CRIT 2
`define LDIC_B_AIS_SUB 1
`define LDIC_B_AUTO_ONES 0
`define LDIC_B_AUTO_REMOTE 3
`define LDIC_B_REMOTE 2
`define LDIC_B_ANALOG 1
`define LDIC_B_DIGITAL 0
`define LDIC_B_TXLEN 4
`define LDIC_B_ACTLEN 2
`define LDIC_B_DEACTLEN 0
`define LDIC_B_BPV_INJ 6
`define LDIC_B_ERR_INJ 5
`define LDIC_B_EXZ_SELECT 4
`define LDIC_B_ERR_SEL 2
`define LDIC_B_CNT_MODE 1
`define LDIC_B_CNT_XFER 0
// ==========================================================
// Timing
`define LDIC_CLK_MHZ 40
`define LDIC_T_SHORT_US 40000
`define LDIC_T_LONG_US 5100000
`endif

// >>> hdl/ldic_pkg.sv
package ldic_pkg;
  typedef struct packed {
    logic eq_out;
    logic act_raw;
    logic deact_raw;
    logic prbs_sync;
    logic tx_clock_loss;
    logic drv_fault;
    logic ais;
    logic los;
  } ldic_line_in_t;
  typedef struct packed {
    logic dac_ov;
    logic ja_ov;
    logic ja_ud;
    logic pat_err;
    logic exz;
    logic cv;
    logic sec_tick;
  } ldic_err_in_t;
  typedef struct packed {
    logic [1:0] inserted_sequence_select;
    logic inserted_sequence_clock_select;
    logic pseudo_random_invert;
    logic los_ais_criterion;
    logic alarm_substitute_active;
    logic auto_ones_active;
    logic remote_loop_active;
    logic analog_loop_enable;
    logic digital_loop_enable;
    logic [1:0] tx_loop_code_length;
    logic [1:0] rx_activate_code_length;
    logic [1:0] rx_deactivate_code_length;
    logic [7:0] tx_loop_code;
    logic [7:0] rx_activate_code;
    logic [7:0] rx_deactivate_code;
    logic excess_zero_definition;
    logic bipolar_violation_inject;
    logic pattern_error_inject;
  } ldic_ctrl_t;
  typedef enum logic {
    LDIC_LB_IDLE = 1'b0,
    LDIC_LB_ACTIVE = 1'b1
  } ldic_lb_state_t;
endpackage

// >>> hdl/ldic_code_persist.sv
`timescale 1ns/100ps
`include "ldic_cfg.svh"
module ldic_code_persist #(
  parameter int SHORT_CYC = 1600000,
  parameter int LONG_CYC = 204000000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic raw,
  input wire logic long_sel,
  output logic detected
);
  logic [27:0] cnt;
  logic [27:0] limit;
  assign limit = long_sel ? LONG_CYC[27:0] : SHORT_CYC[27:0];
  // Code must stay present for the whole window; any dropout restarts it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 28'h0000000;
      detected <= 1'b0;
    end else if (!raw) begin
      cnt <= 28'h0000000;
      detected <= 1'b0;
    end else if (cnt >= limit - 28'h0000001) begin
      detected <= 1'b1;
    end else begin
      cnt <= cnt + 28'h0000001;
    end
  end
endmodule // ldic_code_persist

// >>> hdl/ldic_err_counter.sv
`timescale 1ns/100ps
`include "ldic_cfg.svh"
module ldic_err_counter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] sel,
  input wire logic pat_err,
  input wire logic exz,
  input wire logic cv,
  input wire logic transfer,
  output logic [15:0] result,
  output logic ovf
);
  logic [15:0] cnt;
  logic [1:0] inc;
  logic [16:0] sum;
  always_comb begin
    case (sel)
      2'h0: inc = {1'b0, pat_err};
      2'h1: inc = {1'b0, exz};
      2'h2: inc = {1'b0, cv};
      default: inc = {1'b0, cv} + {1'b0, exz};
    endcase
  end
  assign sum = {1'b0, cnt} + {15'h0000, inc};
  // Events in the transfer cycle start the new count, none is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 16'h0000;
      result <= 16'h0000;
      ovf <= 1'b0;
    end else begin
      ovf <= sum[16] && !transfer;
      if (transfer) begin
        result <= cnt;
        cnt <= {14'h0000, inc};
      end else begin
        cnt <= sum[15:0];
      end
    end
  end
endmodule // ldic_err_counter

// >>> hdl/ldic_top.sv
// What this block does
// - Bits 6-5 pick transmit insertion: normal/zeros, ones, PRBS/QRSS, loop code
// - Bit 4 times the inserted pattern from transmit or master clock
// - Bit 3 inverts the pseudo-random pattern on transmit and detection
// - Bit 2 chooses which LOS/AIS criterion applies
// - Bit 1 substitutes AIS on receive outputs during loss of signal
// - Bit 0 sends all ones during loss of signal, only when insertion is 00
// - Four enables: auto remote, remote, analog and digital loopback
// - Transmit code length field 5..8 bits, reset 5 bits
// - Receive activate code length field 5..8 bits, reset 5 bits
// - Receive deactivate code length field, reset 01 meaning 6 bits
// - Transmit code register, low bits per length, reset 00001
// - Receive activate code register, low bits per length, reset 00001
// - Receive deactivate code register, low bits per length, reset 001001
// - Each rising edge of bit 6 injects exactly one bipolar violation
// - Each rising edge of bit 5 injects exactly one pattern logic error
// - Select bit chooses ANSI or FCC excess-zeros definition
// - Bits 3-2 choose what the 16-bit error counter counts
// - Bit 1 selects manual or automatic counter reporting
// - In manual mode, rising edge of bit 0 copies the count out and clears the counter
// - Sixteen interrupt mask bits reset to 1, a 1 blocks the source
// - Eight edge-select bits: rising only, or either change
// - Reading an interrupt status register clears it; the request drops once no unmasked flag is left in either register
// - Inband code detected after 40 ms, or 5.1 s with auto remote loop
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`include "ldic_cfg.svh"
module ldic_top #(
  parameter int SHORT_CYC = `LDIC_T_SHORT_US * `LDIC_CLK_MHZ,
  parameter int LONG_CYC = `LDIC_T_LONG_US * `LDIC_CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ldic_pkg::ldic_line_in_t line_in,
  input wire ldic_pkg::ldic_err_in_t err_in,
  output ldic_pkg::ldic_ctrl_t ctrl,
  output logic irq
);
  import ldic_pkg::*;

  // ==========================================================
  // Register bus
  logic [7:0] diag_pattern_ctrl;
  logic [7:0] loopback_ctrl;
  logic [7:0] loop_code_length;
  logic [7:0] tx_loop_code;
  logic [7:0] rx_activate_code;
  logic [7:0] rx_deactivate_code;
  logic [7:0] error_inject_count_ctrl;
  logic [7:0] irq_mask_line;
  logic [7:0] irq_mask_errors;
  logic [7:0] irq_edge_select;
  logic [7:0] irq_status_line;
  logic [7:0] irq_status_errors;
  logic [7:0] line_status_a;
  logic [7:0] line_status_prev;
  logic [7:0] inject_prev;
  logic [15:0] count_result;
  logic [5:0] idx;
  logic setup;
  logic wr;
  logic rd;
  logic mapped;
  logic [7:0] rd_val;
  logic clr_line;
  logic clr_err;
  logic [7:0] line_event;
  logic [7:0] err_event;
  logic act_det;
  logic deact_det;
  logic cnt_ovf;
  logic cnt_transfer;
  ldic_lb_state_t lb_state;

  assign idx = paddr[7:2];
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && mapped;
  assign rd = psel && penable && !pwrite && mapped;
  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    mapped = (paddr[1:0] == 2'h0);
    rd_val = 8'h00;
    case (idx)
      `LDIC_IDX_PATTERN: rd_val = diag_pattern_ctrl;
      `LDIC_IDX_LOOP: rd_val = loopback_ctrl;
      `LDIC_IDX_CODE_LEN: rd_val = loop_code_length;
      `LDIC_IDX_TX_CODE: rd_val = tx_loop_code;
      `LDIC_IDX_ACT_CODE: rd_val = rx_activate_code;
      `LDIC_IDX_DEACT_CODE: rd_val = rx_deactivate_code;
      `LDIC_IDX_INJ_CNT: rd_val = error_inject_count_ctrl;
      `LDIC_IDX_MASK_LINE: rd_val = irq_mask_line;
      `LDIC_IDX_MASK_ERR: rd_val = irq_mask_errors;
      `LDIC_IDX_EDGE: rd_val = irq_edge_select;
      `LDIC_IDX_STATUS_A: rd_val = line_status_a;
      `LDIC_IDX_IRQ_LINE: rd_val = irq_status_line;
      `LDIC_IDX_IRQ_ERR: rd_val = irq_status_errors;
      `LDIC_IDX_CNT_LO: rd_val = count_result[7:0];
      `LDIC_IDX_CNT_HI: rd_val = count_result[15:8];
      default: mapped = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle so it is stable for the access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= {24'h000000, rd_val};
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_pattern_ctrl <= `LDIC_RST_PATTERN;
      loopback_ctrl <= `LDIC_RST_LOOP;
      loop_code_length <= `LDIC_RST_CODE_LEN;
      tx_loop_code <= `LDIC_RST_TX_CODE;
      rx_activate_code <= `LDIC_RST_ACT_CODE;
      rx_deactivate_code <= `LDIC_RST_DEACT_CODE;
      error_inject_count_ctrl <= `LDIC_RST_INJ_CNT;
      irq_mask_line <= `LDIC_RST_MASK;
      irq_mask_errors <= `LDIC_RST_MASK;
      irq_edge_select <= `LDIC_RST_EDGE;
    end else if (wr) begin
      case (idx)
        `LDIC_IDX_PATTERN: diag_pattern_ctrl <= pwdata[7:0] & `LDIC_WM_PATTERN;
        `LDIC_IDX_LOOP: loopback_ctrl <= pwdata[7:0] & `LDIC_WM_LOOP;
        `LDIC_IDX_CODE_LEN: loop_code_length <= pwdata[7:0] & `LDIC_WM_CODE_LEN;
        `LDIC_IDX_TX_CODE: tx_loop_code <= pwdata[7:0];
        `LDIC_IDX_ACT_CODE: rx_activate_code <= pwdata[7:0];
        `LDIC_IDX_DEACT_CODE: rx_deactivate_code <= pwdata[7:0];
        `LDIC_IDX_INJ_CNT: error_inject_count_ctrl <= pwdata[7:0] & `LDIC_WM_INJ_CNT;
        `LDIC_IDX_MASK_LINE: irq_mask_line <= pwdata[7:0];
        `LDIC_IDX_MASK_ERR: irq_mask_errors <= pwdata[7:0];
        `LDIC_IDX_EDGE: irq_edge_select <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Code-length masking: unused high bits of a code read back but never leave
  function automatic logic [7:0] ldic_len_mask(input logic [1:0] len);
    logic [7:0] m;
    m = 8'h1F;
    case (len)
      2'h0: m = 8'h1F;
      2'h1: m = 8'h3F;
      2'h2: m = 8'h7F;
      default: m = 8'hFF;
    endcase
    return m;
  endfunction

  // ==========================================================
  // Inband code persistence and automatic remote loopback
  ldic_code_persist #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_act_persist (
    .clk(clk),
    .rst_n(rst_n),
    .raw(line_in.act_raw),
    .long_sel(loopback_ctrl[`LDIC_B_AUTO_REMOTE]),
    .detected(act_det)
  );

  ldic_code_persist #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_deact_persist (
    .clk(clk),
    .rst_n(rst_n),
    .raw(line_in.deact_raw),
    .long_sel(loopback_ctrl[`LDIC_B_AUTO_REMOTE]),
    .detected(deact_det)
  );

  always_comb begin
    line_status_a = {line_in.eq_out, act_det, deact_det, line_in.prbs_sync,
                     line_in.tx_clock_loss, line_in.drv_fault, line_in.ais, line_in.los};
  end

  function automatic logic line_event_rise_act();
    return act_det && !line_status_prev[6];
  endfunction

  // Activate edge switches the loop in, deactivate edge switches it out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lb_state <= LDIC_LB_IDLE;
    end else begin
      case (lb_state)
        LDIC_LB_IDLE:
          if (loopback_ctrl[`LDIC_B_AUTO_REMOTE] && line_event_rise_act()) begin
            lb_state <= LDIC_LB_ACTIVE;
          end
        LDIC_LB_ACTIVE:
          if (!loopback_ctrl[`LDIC_B_AUTO_REMOTE] || (deact_det && !line_status_prev[5])) begin
            lb_state <= LDIC_LB_IDLE;
          end
        default: lb_state <= LDIC_LB_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Control outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else begin
      ctrl.inserted_sequence_select <=
        diag_pattern_ctrl[`LDIC_B_SEQ_HI:`LDIC_B_SEQ_LO];
      ctrl.inserted_sequence_clock_select <= diag_pattern_ctrl[`LDIC_B_SEQ_CLK];
      ctrl.pseudo_random_invert <= diag_pattern_ctrl[`LDIC_B_PR_INVERT];
      ctrl.los_ais_criterion <= diag_pattern_ctrl[`LDIC_B_CRIT];
      ctrl.alarm_substitute_active <= diag_pattern_ctrl[`LDIC_B_AIS_SUB] && line_in.los;
      ctrl.auto_ones_active <= diag_pattern_ctrl[`LDIC_B_AUTO_ONES] && line_in.los
        && (diag_pattern_ctrl[`LDIC_B_SEQ_HI:`LDIC_B_SEQ_LO] == 2'h0);
      ctrl.remote_loop_active <= loopback_ctrl[`LDIC_B_REMOTE] || (lb_state == LDIC_LB_ACTIVE);
      ctrl.analog_loop_enable <= loopback_ctrl[`LDIC_B_ANALOG];
      ctrl.digital_loop_enable <= loopback_ctrl[`LDIC_B_DIGITAL];
      ctrl.tx_loop_code_length <= loop_code_length[`LDIC_B_TXLEN +: 2];
      ctrl.rx_activate_code_length <= loop_code_length[`LDIC_B_ACTLEN +: 2];
      ctrl.rx_deactivate_code_length <= loop_code_length[`LDIC_B_DEACTLEN +: 2];
      ctrl.tx_loop_code <= tx_loop_code & ldic_len_mask(loop_code_length[`LDIC_B_TXLEN +: 2]);
      ctrl.rx_activate_code <=
        rx_activate_code & ldic_len_mask(loop_code_length[`LDIC_B_ACTLEN +: 2]);
      ctrl.rx_deactivate_code <=
        rx_deactivate_code & ldic_len_mask(loop_code_length[`LDIC_B_DEACTLEN +: 2]);
      ctrl.excess_zero_definition <= error_inject_count_ctrl[`LDIC_B_EXZ_SELECT];
      ctrl.bipolar_violation_inject <=
        error_inject_count_ctrl[`LDIC_B_BPV_INJ] && !inject_prev[`LDIC_B_BPV_INJ];
      ctrl.pattern_error_inject <=
        error_inject_count_ctrl[`LDIC_B_ERR_INJ] && !inject_prev[`LDIC_B_ERR_INJ];
    end
  end

  // Rising edges of the self-acting bits; a bit left high fires only once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inject_prev <= 8'h00;
    end else begin
      inject_prev <= error_inject_count_ctrl;
    end
  end

  // ==========================================================
  // Error counter
  assign cnt_transfer = (error_inject_count_ctrl[`LDIC_B_CNT_XFER] && !inject_prev[`LDIC_B_CNT_XFER]
    && !error_inject_count_ctrl[`LDIC_B_CNT_MODE])
    || (error_inject_count_ctrl[`LDIC_B_CNT_MODE] && err_in.sec_tick);

  ldic_err_counter u_counter (
    .clk(clk),
    .rst_n(rst_n),
    .sel(error_inject_count_ctrl[`LDIC_B_ERR_SEL +: 2]),
    .pat_err(err_in.pat_err),
    .exz(err_in.exz),
    .cv(err_in.cv),
    .transfer(cnt_transfer),
    .result(count_result),
    .ovf(cnt_ovf)
  );

  // ==========================================================
  // Interrupt events, flags and request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_status_prev <= 8'h00;
    end else begin
      line_status_prev <= line_status_a;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_edge
      assign line_event[gi] = irq_edge_select[gi] ? (line_status_a[gi] ^ line_status_prev[gi])
        : (line_status_a[gi] && !line_status_prev[gi]);
    end
  endgenerate

  assign err_event = {err_in.dac_ov, err_in.ja_ov, err_in.ja_ud, err_in.pat_err,
                      err_in.exz, err_in.cv, err_in.sec_tick, cnt_ovf};
  assign clr_line = rd && (idx == `LDIC_IDX_IRQ_LINE);
  assign clr_err = rd && (idx == `LDIC_IDX_IRQ_ERR);

  // A new event in the clearing cycle survives the read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_line <= 8'h00;
      irq_status_errors <= 8'h00;
    end else begin
      irq_status_line <= (clr_line ? 8'h00 : irq_status_line) | line_event;
      irq_status_errors <= (clr_err ? 8'h00 : irq_status_errors) | err_event;
    end
  end

  assign irq = (|(irq_status_line & ~irq_mask_line)) || (|(irq_status_errors & ~irq_mask_errors));

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_bpv_rise;
    wr && idx == `LDIC_IDX_INJ_CNT && pwdata[`LDIC_B_BPV_INJ]
      && !error_inject_count_ctrl[`LDIC_B_BPV_INJ];
  endsequence

  sequence s_one_pulse;
    ##2 ctrl.bipolar_violation_inject ##1 !ctrl.bipolar_violation_inject;
  endsequence

  a_bpv_single_pulse: assert property (s_bpv_rise |-> s_one_pulse)
    else $error("bipolar violation inject not a single pulse");

  a_err_inject_edge: assert property (ctrl.pattern_error_inject
    |-> $past(error_inject_count_ctrl[`LDIC_B_ERR_INJ], 1) && !$past(inject_prev[`LDIC_B_ERR_INJ], 1))
    else $error("pattern error inject without rising edge");

  a_auto_ones_gate: assert property (ctrl.auto_ones_active
    |-> $past(line_in.los, 1) && $past(diag_pattern_ctrl[6:5], 1) == 2'h0)
    else $error("auto ones active outside loss or with insertion set");

  a_alarm_sub_los: assert property ($rose(line_in.los) && diag_pattern_ctrl[`LDIC_B_AIS_SUB]
    && $stable(diag_pattern_ctrl) |=> ctrl.alarm_substitute_active)
    else $error("alarm substitution missed during loss");

  a_irq_clear_read: assert property (clr_line && line_event == 8'h00
    && irq_status_errors == 8'h00 && err_event == 8'h00 |=> !irq)
    else $error("interrupt request survived status read");

  a_irq_set_wins: assert property (clr_line && line_event[0] |=> irq_status_line[0])
    else $error("event lost in clearing cycle");

  a_irq_masked_quiet: assert property (irq_mask_line == 8'hFF && irq_mask_errors == 8'hFF |-> !irq)
    else $error("interrupt raised while fully masked");

  a_edge_rising_only: assert property (!irq_edge_select[0] && $fell(line_in.los)
    && !clr_line ##0 irq_status_line[0] == 1'b0 |=> !irq_status_line[0])
    else $error("falling edge flagged in rising-only mode");

  a_trf_copies_count: assert property (cnt_transfer |=> count_result == $past(u_counter.cnt, 1))
    else $error("counter transfer did not copy count");

  a_remote_loop_off: assert property (loopback_ctrl == 8'h00 && lb_state == LDIC_LB_IDLE
    ##1 loopback_ctrl == 8'h00 |-> !ctrl.remote_loop_active)
    else $error("remote loop active with all enables clear");

endmodule // ldic_top

// >>> dv/ldic_top_test.sv
`timescale 1ns/100ps
module ldic_top_test;
  import ldic_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, se;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  ldic_line_in_t line_in;
  ldic_err_in_t err_in;
  ldic_ctrl_t ctrl;
  int n_errors, n_compared, seed, k, np;
  logic [7:0] mdl [int];
  logic [7:0] rst_v [10] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h09, 8'h00, 8'hFF, 8'hFF, 8'h00};
  logic [7:0] wm [10] = '{8'h7F, 8'h0F, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF};

  // Short persistence counts keep the run brief
  ldic_top #(.SHORT_CYC(20), .LONG_CYC(50)) dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in(line_in), .err_in(err_in), .ctrl(ctrl), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // Bus and compare helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 50) begin
      $display("[ERR] pready expected 1 seen %b", pready);
      n_errors++;
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {idx[5:0], 2'b00}, d);
    if (idx >= 8'h0D && idx <= 8'h16) mdl[idx] = d & wm[idx - 8'h0D];
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, {idx[5:0], 2'b00}, 8'h00);
    chk($sformatf("reg %h", idx), {24'h000000, e}, rd);
    chk("slverr", 0, se);
  endtask

  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    $display("[ERR] run expected done seen timeout");
    n_errors++;
    summarize();
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 15;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    line_in = '0;
    err_in = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) mdl[i + 13] = rst_v[i];
    repeat (2) @(posedge clk);
    chk("deact len", 2'b01, ctrl.rx_deactivate_code_length);
    chk("deact code", 8'h09, ctrl.rx_deactivate_code);
    for (int i = 13; i < 23; i++) rdc(8'(i), mdl[i]);
    for (int i = 13; i < 23; i++) begin
      k = $random(seed);
      wr(8'(i), k[7:0]);
      rdc(8'(i), mdl[i]);
    end
    // Misaligned and unmapped accesses must be refused without side effects
    apb(1'b1, 8'h35, 8'hFF);
    chk("slverr", 1, se);
    apb(1'b0, 8'h80, 8'h00);
    chk("slverr", 1, se);
    chk("rdata", 0, rd);
    rdc(8'h0D, mdl[8'h0D]);
    wr(8'h10, 8'hFF);
    wr(8'h11, 8'hFF);
    wr(8'h12, 8'hFF);
    for (int l = 0; l < 4; l++) begin
      wr(8'h0F, 8'(l * 21));
      repeat (3) @(posedge clk);
      k = (1 << (5 + l)) - 1;
      chk("tx code", k, ctrl.tx_loop_code);
      chk("act code", k, ctrl.rx_activate_code);
      chk("deact code", k, ctrl.rx_deactivate_code);
    end
    wr(8'h0E, 8'h07);
    wr(8'h16, 8'h00);
    wr(8'h14, 8'hFE);
    rdc(8'h19, 8'h00);
    line_in.los <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(8'h0D, 8'(s * 32 + 31));
      repeat (3) @(posedge clk);
      chk("sel", s, ctrl.inserted_sequence_select);
      chk("ones", s == 0, ctrl.auto_ones_active);
      chk("ais", 1, ctrl.alarm_substitute_active);
    end
    chk("misc", 3'b111, {ctrl.inserted_sequence_clock_select, ctrl.pseudo_random_invert,
      ctrl.los_ais_criterion});
    chk("loops", 3'b111, {ctrl.remote_loop_active, ctrl.analog_loop_enable, ctrl.digital_loop_enable});
    chk("irq", 1, irq);
    rdc(8'h19, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq", 0, irq);
    line_in.los <= 1'b0;
    wr(8'h0D, 8'h03);
    repeat (3) @(posedge clk);
    chk("ais", 0, ctrl.alarm_substitute_active);
    chk("irq", 0, irq);
    wr(8'h16, 8'h01);
    line_in.los <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(8'h19, 8'h01);
    line_in.los <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq", 1, irq);
    wr(8'h14, 8'hFF);
    repeat (2) @(posedge clk);
    chk("irq", 0, irq);
    // Inband persistence, short window then long window with the auto loop armed
    for (int m = 0; m < 2; m++) begin
      wr(8'h0E, 8'(m * 8));
      line_in.act_raw <= 1'b1;
      repeat (m ? 40 : 12) @(posedge clk);
      rdc(8'h17, 8'h00);
      repeat (20) @(posedge clk);
      rdc(8'h17, 8'h40);
      chk("auto loop", m, ctrl.remote_loop_active);
      line_in.act_raw <= 1'b0;
      line_in.deact_raw <= 1'b1;
      repeat (60) @(posedge clk);
      chk("auto loop", 0, ctrl.remote_loop_active);
      line_in.deact_raw <= 1'b0;
    end
    rdc(8'h1A, 8'h00);
    // One burst of every counted error kind per source setting
    for (int s = 0; s < 4; s++) begin
      k = s * 4 + (s % 2) * 16;
      wr(8'h13, k[7:0]);
      err_in <= 7'h0E;
      @(posedge clk);
      err_in <= '0;
      wr(8'h13, k[7:0] + 8'h01);
      repeat (2) @(posedge clk);
      rdc(8'h1B, (s == 3) ? 8'h02 : 8'h01);
      rdc(8'h1C, 8'h00);
      chk("excess_zero_definition", s % 2, ctrl.excess_zero_definition);
    end
    rdc(8'h1A, 8'h1C);
    // Auto report: the one-second tick alone hands the count over
    wr(8'h13, 8'h02);
    err_in <= 7'h08;
    repeat (2) @(posedge clk);
    err_in <= 7'h01;
    @(posedge clk);
    err_in <= '0;
    repeat (2) @(posedge clk);
    rdc(8'h1B, 8'h02);
    rdc(8'h1A, 8'h12);
    for (int b = 5; b < 7; b++) begin
      for (int r = 0; r < 3; r++) begin
        if (r == 2) wr(8'h13, 8'h00);
        wr(8'h13, 8'(1 << b));
        np = 0;
        repeat (6) begin
          @(posedge clk);
          np += (b == 6) ? ctrl.bipolar_violation_inject : ctrl.pattern_error_inject;
        end
        chk("pulses", (r == 1) ? 0 : 1, np);
      end
    end
    summarize();
  end
endmodule // ldic_top_test
